// file: verilog/node_cfg_pkg.sv
// Constants for the node configuration register bank
package node_cfg_pkg;
  // Register numbers
  localparam logic [7:0] REG_DEVICE_ID      = 8'h00;
  localparam logic [7:0] REG_SWITCH_DESC    = 8'h01;
  localparam logic [7:0] REG_SWITCH_CFG     = 8'h04;
  localparam logic [7:0] REG_NODE_ID        = 8'h05;
  localparam logic [7:0] REG_PLL            = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLK_DIV = 8'h07;
  localparam logic [7:0] REG_REF_CLK_DIV    = 8'h08;
  localparam logic [7:0] REG_JTAG_ID        = 8'h09;
  localparam logic [7:0] REG_USER_CODE      = 8'h0A;
  localparam logic [7:0] REG_DIR_LOW        = 8'h0C;
  localparam logic [7:0] REG_DIR_HIGH       = 8'h0D;
  localparam logic [7:0] REG_DEBUG_CFG0     = 8'h10;
  localparam logic [7:0] REG_DEBUG_CFG1     = 8'h11;
  localparam logic [7:0] REG_DEBUG_SOURCE   = 8'h1F;
  localparam logic [7:0] REG_LINK_STATUS    = 8'h20;
  localparam logic [7:0] REG_PHYS_STATUS    = 8'h40;
  localparam logic [7:0] REG_LINK_CFG       = 8'h80;
  localparam logic [7:0] REG_STATIC_LINK    = 8'hA0;
  // Entry counts of the link register groups
  localparam int LINK_STATUS_COUNT = 9;
  localparam int PHYS_STATUS_COUNT = 8;
  localparam int LINK_CFG_COUNT    = 9;
  localparam int STATIC_LINK_COUNT = 8;
  // Switch configuration field positions
  localparam int CFG_SWITCH_LOCK_BIT = 31;
  localparam int CFG_PLL_LOCK_BIT    = 8;
  localparam int CFG_HEADER_BIT      = 0;
  // Identification fields; values arbitrary
  localparam logic [7:0]  SWITCH_VERSION  = 8'h01;
  localparam logic [7:0]  SWITCH_REVISION = 8'h02;
  localparam logic [31:0] JTAG_ID_VALUE   = 32'h0000_1001;
  localparam logic [31:0] USER_CODE_VALUE = 32'h0000_0000;
  // Switch description counts
  localparam logic [7:0] LINKS_ON_SWITCH  = 8'h08;
  localparam logic [7:0] PROCS_ON_SWITCH  = 8'h02;
  localparam logic [7:0] PROCS_ON_DEVICE  = 8'h02;
  // Reset values
  localparam logic [15:0] SWITCH_CLK_DIV_RESET = 16'h0000;
  localparam logic [15:0] REF_CLK_DIV_RESET    = 16'h0003;
  localparam logic [31:0] PLL_RESET            = 32'h0000_0000;
  // Synchroniser fill time before the boot pins are caught
  localparam logic [1:0] BOOT_SAMPLE_DELAY = 2'h2;
endpackage : node_cfg_pkg

// file: verilog/link_bank_if.sv
// Link register group access between the bank controller and the link store
`timescale 1ns/1ps
interface link_bank_if;
  logic        wrEn;
  logic [7:0]  num;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  logic [255:0] physStatus;
  modport ctrl (output wrEn, output num, output wdata, output physStatus,
                input rdata, input hit);
  modport bank (input wrEn, input num, input wdata, input physStatus,
                output rdata, output hit);
endinterface : link_bank_if

// file: verilog/link_reg_bank.sv
// Link status, physical link status, link config and static link registers
`timescale 1ns/1ps
module link_reg_bank
  import node_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Access
  link_bank_if.bank bus
);
  logic [31:0] linkStatus [LINK_STATUS_COUNT];
  logic [31:0] linkCfg    [LINK_CFG_COUNT];
  logic [31:0] staticLink [STATIC_LINK_COUNT];
  logic [31:0] physMeta   [PHYS_STATUS_COUNT];
  logic [31:0] physSync   [PHYS_STATUS_COUNT];

  genvar i;
  generate
    for (i = 0; i < LINK_CFG_COUNT; i++) begin : g_entry
      if (i < LINK_STATUS_COUNT) begin : g_stat
        always_ff @(posedge ref_clk or posedge rst) begin
          if (rst) linkStatus[i] <= 32'h0000_0000;
          else if (ce && bus.wrEn && bus.num == REG_LINK_STATUS + 8'(i))
            linkStatus[i] <= bus.wdata;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) linkCfg[i] <= 32'h0000_0000;
        else if (ce && bus.wrEn && bus.num == REG_LINK_CFG + 8'(i))
          linkCfg[i] <= bus.wdata;
      end
      if (i < STATIC_LINK_COUNT) begin : g_static
        always_ff @(posedge ref_clk or posedge rst) begin
          if (rst) staticLink[i] <= 32'h0000_0000;
          else if (ce && bus.wrEn && bus.num == REG_STATIC_LINK + 8'(i))
            staticLink[i] <= bus.wdata;
        end
        // Status comes from link logic outside this clock
        always_ff @(posedge ref_clk or posedge rst) begin
          if (rst) begin
            physMeta[i] <= 32'h0000_0000;
            physSync[i] <= 32'h0000_0000;
          end else if (ce) begin
            physMeta[i] <= bus.physStatus[32*i +: 32];
            physSync[i] <= physMeta[i];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    bus.rdata = 32'h0000_0000;
    bus.hit   = 1'b1;
    if (bus.num >= REG_LINK_STATUS && bus.num < REG_LINK_STATUS + 8'(LINK_STATUS_COUNT))
      bus.rdata = linkStatus[4'(bus.num - REG_LINK_STATUS)];
    else if (bus.num >= REG_PHYS_STATUS
             && bus.num < REG_PHYS_STATUS + 8'(PHYS_STATUS_COUNT))
      bus.rdata = physSync[3'(bus.num - REG_PHYS_STATUS)];
    else if (bus.num >= REG_LINK_CFG && bus.num < REG_LINK_CFG + 8'(LINK_CFG_COUNT))
      bus.rdata = linkCfg[4'(bus.num - REG_LINK_CFG)];
    else if (bus.num >= REG_STATIC_LINK
             && bus.num < REG_STATIC_LINK + 8'(STATIC_LINK_COUNT))
      bus.rdata = staticLink[3'(bus.num - REG_STATIC_LINK)];
    else
      bus.hit = 1'b0;
  end
endmodule : link_reg_bank

// file: verilog/node_config_register_bank.sv
// Node configuration register bank reached by configuration reads and writes
//
// How it works
// - Access only via configuration read/write transactions
// - Boot pins latched once after reset release, bits 23:16
// - Revision 15:8, version 7:0, 31:24 reserved
// - Description: links, switch processors, device processors
// - Bit 8 blocks PLL control writes
// - Node identifier 16 bits writable, upper reserved
// - JTAG ID and user code ignore writes
// - Physical status read-only; link configs writable
`timescale 1ns/1ps
module node_config_register_bank
  import node_cfg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Configuration transactions
  input  wire logic         cfgValid,
  input  wire logic         cfgWrite,
  input  wire logic [7:0]   cfgNum,
  input  wire logic [31:0]  cfgWdata,
  output logic              cfgDone,
  output logic [31:0]       cfgRdata,
  // Pins and link status
  input  wire logic [7:0]   bootControlPins,
  input  wire logic [255:0] physLinkStatus,
  input  wire logic [2:0]   debugSource,
  // Control outputs
  output logic              headerOneByte,
  output logic [15:0]       nodeId,
  output logic [31:0]       pllSettings,
  output logic              pllWritten,
  output logic [15:0]       switchClockDivider,
  output logic [15:0]       refClockDivider,
  output logic [63:0]       routeDirections,
  output logic [3:0]        debugPinConfig
);
  link_bank_if linkBus ();

  logic        switchLock;
  logic        pllLock;
  logic [7:0]  bootMeta;
  logic [7:0]  bootSync;
  logic [7:0]  bootLatched;
  logic [1:0]  bootCount;
  logic        bootDone;
  logic [2:0]  debugMeta;
  logic [2:0]  debugSync;
  logic        take;
  logic        wr;
  logic        switchWrite;
  logic [31:0] next_rdata;

  assign take = ce && cfgValid;
  assign wr   = take && cfgWrite;
  assign switchWrite = wr && !switchLock;

  assign linkBus.wrEn       = switchWrite;
  assign linkBus.num        = cfgNum;
  assign linkBus.wdata      = cfgWdata;
  assign linkBus.physStatus = physLinkStatus;

  link_reg_bank u_links (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .bus     (linkBus.bank)
  );

  // Pin inputs through two flops before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bootMeta  <= 8'h00;
      bootSync  <= 8'h00;
      debugMeta <= 3'h0;
      debugSync <= 3'h0;
    end else if (ce) begin
      bootMeta  <= bootControlPins;
      bootSync  <= bootMeta;
      debugMeta <= debugSource;
      debugSync <= debugMeta;
    end
  end

  // Catch boot pins once after release
  // Wait for the synchroniser to fill so reset zeros are not caught
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bootCount   <= 2'h0;
      bootDone    <= 1'b0;
      bootLatched <= 8'h00;
    end else if (ce && !bootDone) begin
      if (bootCount == BOOT_SAMPLE_DELAY) begin
        bootLatched <= bootSync;
        bootDone    <= 1'b1;
      end else begin
        bootCount <= bootCount + 2'h1;
      end
    end
  end

  // Switch configuration; the lock bits themselves stay writable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switchLock    <= 1'b0;
      pllLock       <= 1'b0;
      headerOneByte <= 1'b0;
    end else if (wr && cfgNum == REG_SWITCH_CFG) begin
      switchLock    <= cfgWdata[CFG_SWITCH_LOCK_BIT];
      pllLock       <= cfgWdata[CFG_PLL_LOCK_BIT];
      headerOneByte <= cfgWdata[CFG_HEADER_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) nodeId <= 16'h0000;
    else if (switchWrite && cfgNum == REG_NODE_ID) nodeId <= cfgWdata[15:0];
  end

  // PLL register honours its own lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pllSettings <= PLL_RESET;
      pllWritten  <= 1'b0;
    end else if (ce) begin
      pllWritten <= 1'b0;
      if (wr && !pllLock && cfgNum == REG_PLL) begin
        pllSettings <= cfgWdata;
        pllWritten  <= 1'b1;
      end
    end
  end

  // Clock dividers under the switch lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switchClockDivider <= SWITCH_CLK_DIV_RESET;
      refClockDivider    <= REF_CLK_DIV_RESET;
    end else if (switchWrite) begin
      if (cfgNum == REG_SWITCH_CLK_DIV) switchClockDivider <= cfgWdata[15:0];
      if (cfgNum == REG_REF_CLK_DIV) refClockDivider <= cfgWdata[15:0];
    end
  end

  // Routing and debug pin setup under the switch lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      routeDirections <= 64'h0000_0000_0000_0000;
      debugPinConfig  <= 4'h0;
    end else if (switchWrite) begin
      if (cfgNum == REG_DIR_LOW) routeDirections[31:0] <= cfgWdata;
      if (cfgNum == REG_DIR_HIGH) routeDirections[63:32] <= cfgWdata;
      if (cfgNum == REG_DEBUG_CFG0) debugPinConfig[1:0] <= cfgWdata[1:0];
      if (cfgNum == REG_DEBUG_CFG1) debugPinConfig[3:2] <= cfgWdata[1:0];
    end
  end

  // Read mux; unmapped numbers read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (cfgNum)
      REG_DEVICE_ID:      next_rdata = {8'h00, bootLatched, SWITCH_REVISION, SWITCH_VERSION};
      REG_SWITCH_DESC:    next_rdata = {8'h00, LINKS_ON_SWITCH, PROCS_ON_SWITCH,
                                        PROCS_ON_DEVICE};
      REG_SWITCH_CFG: begin
        next_rdata[CFG_SWITCH_LOCK_BIT] = switchLock;
        next_rdata[CFG_PLL_LOCK_BIT]    = pllLock;
        next_rdata[CFG_HEADER_BIT]      = headerOneByte;
      end
      REG_NODE_ID:        next_rdata = {16'h0000, nodeId};
      REG_PLL:            next_rdata = pllSettings;
      REG_SWITCH_CLK_DIV: next_rdata = {16'h0000, switchClockDivider};
      REG_REF_CLK_DIV:    next_rdata = {16'h0000, refClockDivider};
      REG_JTAG_ID:        next_rdata = JTAG_ID_VALUE;
      REG_USER_CODE:      next_rdata = USER_CODE_VALUE;
      REG_DIR_LOW:        next_rdata = routeDirections[31:0];
      REG_DIR_HIGH:       next_rdata = routeDirections[63:32];
      REG_DEBUG_CFG0:     next_rdata = {30'h0000_0000, debugPinConfig[1:0]};
      REG_DEBUG_CFG1:     next_rdata = {30'h0000_0000, debugPinConfig[3:2]};
      REG_DEBUG_SOURCE:   next_rdata = {27'h000_0000, debugSync[2], 2'h0, debugSync[1:0]};
      default:            next_rdata = linkBus.hit ? linkBus.rdata : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgDone  <= 1'b0;
      cfgRdata <= 32'h0000_0000;
    end else if (ce) begin
      cfgDone <= cfgValid;
      if (take && !cfgWrite) cfgRdata <= next_rdata;
    end
  end
endmodule : node_config_register_bank

// file: tb/node_config_register_bank_monitor.sv
// Assertion checker for the node configuration register bank
`timescale 1ns/1ps
module node_config_register_bank_monitor
  import node_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        ce,
  // Transactions
  input wire logic        cfgValid,
  input wire logic        cfgWrite,
  input wire logic [7:0]  cfgNum,
  input wire logic [31:0] cfgWdata,
  input wire logic        cfgDone,
  input wire logic [31:0] cfgRdata,
  // Controls
  input wire logic        headerOneByte,
  input wire logic [15:0] nodeId,
  input wire logic [31:0] pllSettings,
  input wire logic        pllWritten
);
  logic swLock;
  logic pllLock;
  logic wr;
  logic rd;
  assign wr = ce && cfgValid && cfgWrite;
  assign rd = ce && cfgValid && !cfgWrite;
  // Own copy of the protect bits, so lock checks do not trust the design
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      swLock  <= 1'b0;
      pllLock <= 1'b0;
    end else if (wr && cfgNum == REG_SWITCH_CFG) begin
      swLock  <= cfgWdata[CFG_SWITCH_LOCK_BIT];
      pllLock <= cfgWdata[CFG_PLL_LOCK_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_done; (ce && cfgValid) |=> cfgDone; endproperty
  property p_idle; (ce && !cfgValid) |=> !cfgDone; endproperty
  property p_header; (wr && cfgNum == REG_SWITCH_CFG) |=>
    headerOneByte == $past(cfgWdata[CFG_HEADER_BIT]); endproperty
  property p_node_wr; (wr && cfgNum == REG_NODE_ID && !swLock) |=>
    nodeId == $past(cfgWdata[15:0]); endproperty
  property p_node_lock; (wr && cfgNum == REG_NODE_ID && swLock) |=> $stable(nodeId); endproperty
  property p_pll_wr; (wr && cfgNum == REG_PLL && !pllLock) |=>
    pllWritten && pllSettings == $past(cfgWdata); endproperty
  property p_pll_lock; (wr && cfgNum == REG_PLL && pllLock) |=>
    !pllWritten && $stable(pllSettings); endproperty
  property p_desc; (rd && cfgNum == REG_SWITCH_DESC) |=>
    cfgRdata == {8'h00, LINKS_ON_SWITCH, PROCS_ON_SWITCH, PROCS_ON_DEVICE}; endproperty
  property p_jtag; (rd && cfgNum == REG_JTAG_ID) |=> cfgRdata == JTAG_ID_VALUE; endproperty
  a_done: assert property (p_done) else $error("no completion");
  a_idle: assert property (p_idle) else $error("stray completion");
  a_header: assert property (p_header) else $error("header mode wrong");
  a_node_wr: assert property (p_node_wr) else $error("node id not written");
  a_node_lock: assert property (p_node_lock) else $error("locked node id moved");
  a_pll_wr: assert property (p_pll_wr) else $error("pll not written");
  a_pll_lock: assert property (p_pll_lock) else $error("locked pll moved");
  a_desc: assert property (p_desc) else $error("description wrong");
  a_jtag: assert property (p_jtag) else $error("jtag id wrong");
  c_node_lock: cover property (wr && cfgNum == REG_NODE_ID && swLock);
  c_pll_lock: cover property (wr && cfgNum == REG_PLL && pllLock);
  c_read: cover property (rd ##1 cfgDone);
endmodule : node_config_register_bank_monitor

bind node_config_register_bank node_config_register_bank_monitor uMonitor (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .cfgValid(cfgValid), .cfgWrite(cfgWrite),
  .cfgNum(cfgNum), .cfgWdata(cfgWdata), .cfgDone(cfgDone), .cfgRdata(cfgRdata),
  .headerOneByte(headerOneByte), .nodeId(nodeId), .pllSettings(pllSettings),
  .pllWritten(pllWritten));

// file: tb/cfg_requester.sv
// Configuration requester model issuing reads and writes to the bank
`timescale 1ns/1ps
module cfg_requester (
  // Clock
  input wire logic        ref_clk,
  // Transaction
  output logic            cfgValid,
  output logic            cfgWrite,
  output logic [7:0]      cfgNum,
  output logic [31:0]     cfgWdata,
  input wire logic        cfgDone,
  input wire logic [31:0] cfgRdata
);
  initial begin
    cfgValid = 1'b0;
    cfgWrite = 1'b0;
    cfgNum   = 8'h00;
    cfgWdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] num, input logic [31:0] data,
                      input int gap, output logic done, output logic [31:0] rdata);
    int n;
    n = 0;
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    cfgValid <= 1'b1;
    cfgWrite <= w;
    cfgNum   <= num;
    cfgWdata <= data;
    @(posedge ref_clk);
    // Released lines carry junk, not the last value
    cfgValid <= 1'b0;
    cfgWrite <= ~w;
    cfgNum   <= ~num;
    cfgWdata <= ~data;
    @(posedge ref_clk);
    while (cfgDone !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      n++;
    end
    done  = cfgDone;
    rdata = cfgRdata;
  endtask : xfer
endmodule : cfg_requester

// file: tb/node_config_register_bank_tb.sv
// Self-checking bench for the node configuration register bank
`timescale 1ns/1ps
module node_config_register_bank_tb
  import node_cfg_pkg::*;
;
  localparam logic [31:0] PHYS_WORD = 32'h1357_9BDF;
  localparam logic [31:0] PHYS_TOP  = 32'h2468_ACE0;
  localparam logic [7:0]  BOOT_PINS = 8'hA5;
  localparam int          NT        = 19;
  logic         ref_clk;
  logic         rst;
  logic         ce;
  logic         cfgValid;
  logic         cfgWrite;
  logic [7:0]   cfgNum;
  logic [31:0]  cfgWdata;
  logic         cfgDone;
  logic [31:0]  cfgRdata;
  logic [7:0]   bootControlPins;
  logic [255:0] physLinkStatus;
  logic [2:0]   debugSource;
  logic         headerOneByte;
  logic [15:0]  nodeId;
  logic [31:0]  pllSettings;
  logic [15:0]  switchClockDivider;
  logic [15:0]  refClockDivider;
  logic [63:0]  routeDirections;
  logic [3:0]   debugPinConfig;
  int           errorCnt;
  int           checksDone;
  int           cycles;
  logic         xDone;
  logic [31:0]  xRdata;
  logic [7:0]   tNum [NT] = '{REG_JTAG_ID, REG_USER_CODE, REG_NODE_ID, REG_SWITCH_CFG,
    REG_DEBUG_SOURCE, REG_PHYS_STATUS, REG_LINK_CFG, REG_STATIC_LINK, 8'hFF,
    REG_DEVICE_ID, REG_SWITCH_DESC, REG_SWITCH_CLK_DIV, REG_REF_CLK_DIV, REG_DIR_LOW,
    REG_DIR_HIGH, REG_DEBUG_CFG0, REG_DEBUG_CFG1, REG_LINK_STATUS + 8'h08,
    REG_PHYS_STATUS + 8'h07};
  logic [31:0]  tWr [NT] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h7FFF_FEFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h5A5A_5A5A, 32'h3C3C_3C3C, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1234_ABCD, 32'h1111_2222,
    32'h3333_4444, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'h9999_AAAA, 32'hFFFF_FFFF};
  logic [31:0]  tExp [NT] = '{JTAG_ID_VALUE, USER_CODE_VALUE, 32'h0000_FFFF, 32'h0000_0001,
    32'h0000_0011, PHYS_WORD, 32'h5A5A_5A5A, 32'h3C3C_3C3C, 32'h0000_0000,
    {8'h00, BOOT_PINS, SWITCH_REVISION, SWITCH_VERSION},
    {8'h00, LINKS_ON_SWITCH, PROCS_ON_SWITCH, PROCS_ON_DEVICE}, 32'h0000_FFFF, 32'h0000_ABCD,
    32'h1111_2222, 32'h3333_4444, 32'h0000_0003, 32'h0000_0002, 32'h9999_AAAA, PHYS_TOP};

  node_config_register_bank uut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgNum(cfgNum), .cfgWdata(cfgWdata),
    .cfgDone(cfgDone), .cfgRdata(cfgRdata), .bootControlPins(bootControlPins),
    .physLinkStatus(physLinkStatus), .debugSource(debugSource),
    .headerOneByte(headerOneByte), .nodeId(nodeId), .pllSettings(pllSettings),
    .pllWritten(), .switchClockDivider(switchClockDivider),
    .refClockDivider(refClockDivider), .routeDirections(routeDirections),
    .debugPinConfig(debugPinConfig));
  cfg_requester uReq (.ref_clk(ref_clk), .cfgValid(cfgValid), .cfgWrite(cfgWrite),
    .cfgNum(cfgNum), .cfgWdata(cfgWdata), .cfgDone(cfgDone), .cfgRdata(cfgRdata));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic summarize();
    if (errorCnt == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] num, input logic [31:0] data, input int gap = 0);
    logic        done;
    logic [31:0] rdata;
    uReq.xfer(1'b1, num, data, gap, done, rdata);
    check("cfgDone", {31'h0, done}, 32'h1);
  endtask : wr

  task automatic rd(input logic [7:0] num, input logic [31:0] exp);
    logic        done;
    logic [31:0] rdata;
    uReq.xfer(1'b0, num, 32'h0, 0, done, rdata);
    check("cfgDone", {31'h0, done}, 32'h1);
    check($sformatf("reg %h", num), rdata, exp);
  endtask : rd

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errorCnt++;
      summarize();
    end
  end

  initial begin
    ce = 1'b1;
    rst = 1'b1;
    bootControlPins = BOOT_PINS;
    // Distinct top entry catches a wrong status index
    physLinkStatus = {PHYS_TOP, {7{PHYS_WORD}}};
    debugSource = 3'h5;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(REG_DEVICE_ID, {8'h00, 8'hA5, SWITCH_REVISION, SWITCH_VERSION});
    rd(REG_SWITCH_DESC, {8'h00, LINKS_ON_SWITCH, PROCS_ON_SWITCH, PROCS_ON_DEVICE});
    rd(REG_SWITCH_CFG, 32'h0);
    rd(REG_NODE_ID, 32'h0);
    check("refClockDivider", {16'h0, refClockDivider}, {16'h0, REF_CLK_DIV_RESET});
    check("switchClockDivider", {16'h0, switchClockDivider},
          {16'h0, SWITCH_CLK_DIV_RESET});
    for (int i = 0; i < NT; i++) begin
      wr(tNum[i], tWr[i]);
      rd(tNum[i], tExp[i]);
    end
    check("headerOneByte", {31'h0, headerOneByte}, 32'h1);
    check("switchClockDivider", {16'h0, switchClockDivider}, 32'h0000_FFFF);
    check("refClockDivider", {16'h0, refClockDivider}, 32'h0000_ABCD);
    check("routeLow", routeDirections[31:0], 32'h1111_2222);
    check("routeHigh", routeDirections[63:32], 32'h3333_4444);
    check("debugPinConfig", {28'h0, debugPinConfig}, 32'h0000_000B);
    wr(REG_PLL, 32'hA5A5_A5A5);
    check("pllSettings", pllSettings, 32'hA5A5_A5A5);
    wr(REG_SWITCH_CFG, 32'h0000_0100);
    check("headerOneByte", {31'h0, headerOneByte}, 32'h0);
    wr(REG_PLL, 32'h1234_5678);
    rd(REG_PLL, 32'hA5A5_A5A5);
    wr(REG_SWITCH_CFG, 32'h8000_0000);
    wr(REG_REF_CLK_DIV, 32'h0);
    check("refClockDivider", {16'h0, refClockDivider}, 32'h0000_ABCD);
    wr(REG_DIR_LOW, 32'h0);
    rd(REG_DIR_LOW, 32'h1111_2222);
    // Switch lock leaves the PLL register open
    wr(REG_PLL, 32'h0F0F_0F0F);
    check("pllSettings", pllSettings, 32'h0F0F_0F0F);
    wr(REG_NODE_ID, 32'h0000_1234);
    check("nodeId", {16'h0, nodeId}, 32'h0000_FFFF);
    wr(REG_LINK_CFG, 32'h0);
    rd(REG_LINK_CFG, 32'h5A5A_5A5A);
    rd(REG_SWITCH_CFG, 32'h8000_0000);
    wr(REG_SWITCH_CFG, 32'h0);
    wr(REG_NODE_ID, 32'h0000_1234, 3);
    check("nodeId", {16'h0, nodeId}, 32'h0000_1234);
    // Enable low: request not taken, nothing moves
    ce <= 1'b0;
    uReq.xfer(1'b1, REG_NODE_ID, 32'h0000_5555, 0, xDone, xRdata);
    ce <= 1'b1;
    check("cfgDone", {31'h0, xDone}, 32'h0);
    check("nodeId", {16'h0, nodeId}, 32'h0000_1234);
    // Second reset mid-run; boot pins caught again
    bootControlPins <= 8'h3C;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("nodeId", {16'h0, nodeId}, 32'h0);
    check("refClockDivider", {16'h0, refClockDivider}, {16'h0, REF_CLK_DIV_RESET});
    rd(REG_SWITCH_CFG, 32'h0);
    rd(REG_PLL, PLL_RESET);
    rd(REG_DEVICE_ID, {8'h00, 8'h3C, SWITCH_REVISION, SWITCH_VERSION});
    summarize();
  end
endmodule : node_config_register_bank_tb
